/* File: inc/msgbuf_defs.svh */
// constants of the message buffer port: offsets, fields, sizes
// assumes byte addresses on a 32-bit AHB-Lite bus, low 12 bits decoded
`ifndef MSGBUF_DEFS_SVH
`define MSGBUF_DEFS_SVH
`define MSGBUF_DEPTH       96
`define MSGBUF_AW          12
`define MSGBUF_OFF_BUF0    12'h600
`define MSGBUF_OFF_BUF1    12'h700
`define MSGBUF_OFF_CTRL    12'h000
`define MSGBUF_OFF_STAT    12'h004
`define MSGBUF_OFF_MASK    12'h008
`define MSGBUF_OFF_PTR     12'h00c
`define MSGBUF_CTRL_SEL_LO 0
`define MSGBUF_CTRL_SEL_HI 1
`define MSGBUF_CTRL_RST0   8
`define MSGBUF_CTRL_RST1   9
`define MSGBUF_EV_RX_END_OF_TRANSFER_EVENT    0
`define MSGBUF_EV_TXSENT   1
`define MSGBUF_NEV         2
`define MSGBUF_SEL_RESET   2'h0
`endif

/* File: inc/msgbuf_pkg.sv */
// types shared by the message buffer port modules
// assumes msgbuf_defs.svh is on the include path
package msgbuf_pkg;
	typedef enum logic [0:0] {BUS_IDLE, BUS_RESP} bus_st_t;
	typedef enum logic [2:0] {
		REG_NONE, REG_BUF0, REG_BUF1, REG_CTRL, REG_STAT, REG_MASK, REG_PTR
	} reg_sel_t;
endpackage

/* File: inc/msgbuf_mem_if.sv */
// two-port byte memory connection between port logic and storage
// port a serves software, port b the hdlc engine; read data registered
interface msgbuf_mem_if;
	logic       a_en;
	logic       a_we;
	logic [7:0] a_addr;
	logic [7:0] a_wdata;
	logic [7:0] a_rdata;
	logic       b_en;
	logic       b_we;
	logic [7:0] b_addr;
	logic [7:0] b_wdata;
	logic [7:0] b_rdata;
	modport ctl (output a_en, a_we, a_addr, a_wdata, b_en, b_we, b_addr,
		b_wdata, input a_rdata, b_rdata);
	modport mem (input a_en, a_we, a_addr, a_wdata, b_en, b_we, b_addr,
		b_wdata, output a_rdata, b_rdata);
endinterface

/* File: core/msgbuf_mem.sv */
// storage for the two message buffers, laid end to end
// assumes one clock; read data valid the cycle after an enabled read
`include "msgbuf_defs.svh"
module msgbuf_mem #(
	parameter int DEPTH = `MSGBUF_DEPTH
) (
	input  wire logic clk,
	msgbuf_mem_if.mem m
);
	localparam int SIZE = 2 * DEPTH;
	logic [7:0] store [SIZE];
	logic [7:0] ra;
	logic [7:0] rb;

	// engine write first so software wins a same-address collision
	always_ff @(posedge clk) begin
		if (m.b_en && m.b_we && (int'(m.b_addr) < SIZE)) begin
			store[m.b_addr] <= m.b_wdata;
		end
		if (m.a_en && m.a_we && (int'(m.a_addr) < SIZE)) begin
			store[m.a_addr] <= m.a_wdata;
		end
		if (m.a_en && !m.a_we) begin
			ra <= (int'(m.a_addr) < SIZE) ? store[m.a_addr] : 8'h00;
		end
		if (m.b_en && !m.b_we) begin
			rb <= (int'(m.b_addr) < SIZE) ? store[m.b_addr] : 8'h00;
		end
	end
	assign m.a_rdata = ra;
	assign m.b_rdata = rb;
endmodule // msgbuf_mem

/* File: core/msgbuf_irq.sv */
// sticky event status, mask and one level interrupt
// assumes clr is a one-cycle pulse issued when status is read
`include "msgbuf_defs.svh"
module msgbuf_irq #(
	parameter int NEV = `MSGBUF_NEV
) (
	input  wire logic           clk,
	input  wire logic           rst_n,
	input  wire logic [NEV-1:0] set,
	input  wire logic           clr,
	input  wire logic           mask_we,
	input  wire logic [NEV-1:0] mask_wdata,
	output logic      [NEV-1:0] status,
	output logic      [NEV-1:0] mask,
	output logic                irq
);
	typedef struct packed {
		logic [NEV-1:0] status;
		logic [NEV-1:0] mask;
		logic           irq;
	} irq_state_t;
	irq_state_t s;
	irq_state_t next_s;

	// a set in the clearing cycle survives the clear
	always_comb begin
		next_s = s;
		next_s.status = (clr ? '0 : s.status) | set;
		if (mask_we) begin
			next_s.mask = mask_wdata;
		end
		next_s.irq = |(s.status & s.mask);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
	assign status = s.status;
	assign mask   = s.mask;
	assign irq    = s.irq;

	chk_irq_follows: assert property (@(posedge clk) disable iff (!rst_n)
		|(s.status & s.mask) |=> irq)
		else $error("irq not raised for unmasked status");
endmodule // msgbuf_irq

/* File: core/lapd_msg_port.sv */
// message buffer port: two auto-incrementing byte windows onto the
// 96-byte message buffers shared by the transmit and receive engines
// assumes one clock, engine signals synchronous, AHB-Lite single master
// How it works
// - each buffer holds 96 bytes, one byte port
// - every port access advances the byte pointer, unless an engine event for that buffer restarts it in the same cycle
// - only the selected controller reaches the buffers
// - sent message is no longer readable by software
// - repeated buffer 0 reads return the received message
// - buffer 1 has its own separate byte port
// - buffer 1 behaves exactly like buffer 0
//
// Design decision made here: the AHB-Lite interface to the registers.
`include "msgbuf_defs.svh"
module lapd_msg_port #(
	parameter int DEPTH = `MSGBUF_DEPTH
) (
	input  wire logic        CLK,
	input  wire logic        ARST_N,
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic      [31:0] HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	output logic             IRQ,
	output logic      [1:0]  CTRL_SEL,
	input  wire logic [1:0]  ENG_CTRL,
	input  wire logic        ENG_RD,
	input  wire logic        ENG_WR,
	input  wire logic        ENG_BUF,
	input  wire logic [6:0]  ENG_ADDR,
	input  wire logic [7:0]  ENG_WDATA,
	output logic      [7:0]  ENG_RDATA,
	input  wire logic        ENG_TX_SENT,
	input  wire logic        ENG_RX_EOT
);
	typedef struct packed {
		msgbuf_pkg::bus_st_t  bst;
		msgbuf_pkg::reg_sel_t rsel;
		logic                 wr;
		logic [6:0]           ptr0;
		logic [6:0]           ptr1;
		logic [1:0]           spent;
		logic [1:0]           sel;
		logic [31:0]          hrdata;
		logic                 hreadyout;
	} port_state_t;

	localparam logic [6:0] LAST = 7'(DEPTH - 1);
	localparam logic [7:0] BASE1 = 8'(DEPTH);

	port_state_t s;
	port_state_t next_s;
	logic [1:0]  rst_sync;
	logic        rst_n;
	msgbuf_mem_if mi ();

	logic                 accept;
	msgbuf_pkg::reg_sel_t dec;
	logic                 eng_ok;
	logic [`MSGBUF_NEV-1:0] ev_set;
	logic                 stat_clr;
	logic                 mask_we;
	logic [`MSGBUF_NEV-1:0] status;
	logic [`MSGBUF_NEV-1:0] mask;
	logic                 irq_w;

	// reset release through two flops, assertion stays asynchronous
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	msgbuf_mem #(
		.DEPTH (DEPTH)
	) u_mem (
		.clk (CLK),
		.m   (mi.mem)
	);

	msgbuf_irq #(
		.NEV (`MSGBUF_NEV)
	) u_irq (
		.clk        (CLK),
		.rst_n      (rst_n),
		.set        (ev_set),
		.clr        (stat_clr),
		.mask_we    (mask_we),
		.mask_wdata (HWDATA[`MSGBUF_NEV-1:0]),
		.status     (status),
		.mask       (mask),
		.irq        (irq_w)
	);

	// address phase decode; only the low 12 address bits are looked at
	always_comb begin
		unique case (HADDR[`MSGBUF_AW-1:0])
			`MSGBUF_OFF_BUF0: dec = msgbuf_pkg::REG_BUF0;
			`MSGBUF_OFF_BUF1: dec = msgbuf_pkg::REG_BUF1;
			`MSGBUF_OFF_CTRL: dec = msgbuf_pkg::REG_CTRL;
			`MSGBUF_OFF_STAT: dec = msgbuf_pkg::REG_STAT;
			`MSGBUF_OFF_MASK: dec = msgbuf_pkg::REG_MASK;
			`MSGBUF_OFF_PTR:  dec = msgbuf_pkg::REG_PTR;
			default:          dec = msgbuf_pkg::REG_NONE;
		endcase
	end
	assign accept = HSEL && HTRANS[1] && HREADY && (s.bst == msgbuf_pkg::BUS_IDLE);

	// engine only reaches memory while it is the selected controller
	assign eng_ok = (ENG_CTRL == s.sel);
	assign ev_set[`MSGBUF_EV_RX_END_OF_TRANSFER_EVENT]  = ENG_RX_EOT && eng_ok;
	assign ev_set[`MSGBUF_EV_TXSENT] = ENG_TX_SENT && eng_ok;

	// engine port, straight through to memory port b
	always_comb begin
		mi.b_en    = (ENG_RD || ENG_WR) && eng_ok;
		mi.b_we    = ENG_WR;
		// an index past the buffer end is parked outside both buffers,
		// so a stray engine write cannot spill into the other buffer
		if (ENG_ADDR > LAST) begin
			mi.b_addr = 8'hff;
		end else begin
			mi.b_addr = (ENG_BUF ? BASE1 : 8'h00) + {1'b0, ENG_ADDR};
		end
		mi.b_wdata = ENG_WDATA;
	end

	// software port a: reads issued in address phase, writes in data phase
	always_comb begin
		mi.a_en    = 1'b0;
		mi.a_we    = 1'b0;
		mi.a_addr  = 8'h00;
		mi.a_wdata = HWDATA[7:0];
		if (accept && !HWRITE && (dec == msgbuf_pkg::REG_BUF0)) begin
			mi.a_en   = 1'b1;
			mi.a_addr = {1'b0, s.ptr0};
		end else if (accept && !HWRITE && (dec == msgbuf_pkg::REG_BUF1)) begin
			mi.a_en   = 1'b1;
			mi.a_addr = BASE1 + {1'b0, s.ptr1};
		end else if ((s.bst == msgbuf_pkg::BUS_RESP) && s.wr) begin
			if (s.rsel == msgbuf_pkg::REG_BUF0) begin
				mi.a_en   = 1'b1;
				mi.a_we   = 1'b1;
				mi.a_addr = {1'b0, s.ptr0};
			end else if (s.rsel == msgbuf_pkg::REG_BUF1) begin
				mi.a_en   = 1'b1;
				mi.a_we   = 1'b1;
				mi.a_addr = BASE1 + {1'b0, s.ptr1};
			end
		end
	end

	assign stat_clr = (s.bst == msgbuf_pkg::BUS_RESP) && !s.wr &&
		(s.rsel == msgbuf_pkg::REG_STAT);
	assign mask_we = (s.bst == msgbuf_pkg::BUS_RESP) && s.wr &&
		(s.rsel == msgbuf_pkg::REG_MASK);

	// bus sequencing, pointers and buffer bookkeeping
	always_comb begin
		logic adv0;
		logic adv1;
		logic rs0;
		logic rs1;
		adv0 = 1'b0;
		adv1 = 1'b0;
		rs0  = 1'b0;
		rs1  = 1'b0;
		next_s = s;
		next_s.hreadyout = 1'b1;
		unique case (s.bst)
			msgbuf_pkg::BUS_IDLE: begin
				if (accept) begin
					// one wait state for every transfer keeps hrdata a flop
					next_s.bst       = msgbuf_pkg::BUS_RESP;
					next_s.rsel      = dec;
					next_s.wr        = HWRITE;
					next_s.hreadyout = 1'b0;
					adv0 = !HWRITE && (dec == msgbuf_pkg::REG_BUF0);
					adv1 = !HWRITE && (dec == msgbuf_pkg::REG_BUF1);
				end
			end
			msgbuf_pkg::BUS_RESP: begin
				next_s.bst    = msgbuf_pkg::BUS_IDLE;
				next_s.hrdata = 32'h0000_0000;
				if (s.wr) begin
					unique case (s.rsel)
						msgbuf_pkg::REG_BUF0: begin
							adv0 = 1'b1;
							next_s.spent[0] = 1'b0;
						end
						msgbuf_pkg::REG_BUF1: begin
							adv1 = 1'b1;
							next_s.spent[1] = 1'b0;
						end
						msgbuf_pkg::REG_CTRL: begin
							next_s.sel = HWDATA[`MSGBUF_CTRL_SEL_HI:`MSGBUF_CTRL_SEL_LO];
							rs0 = HWDATA[`MSGBUF_CTRL_RST0];
							rs1 = HWDATA[`MSGBUF_CTRL_RST1];
						end
						default: begin
						end
					endcase
				end else begin
					unique case (s.rsel)
						// a sent buffer reads as zero until rewritten
						msgbuf_pkg::REG_BUF0:
							next_s.hrdata[7:0] = s.spent[0] ? 8'h00 : mi.a_rdata;
						msgbuf_pkg::REG_BUF1:
							next_s.hrdata[7:0] = s.spent[1] ? 8'h00 : mi.a_rdata;
						msgbuf_pkg::REG_CTRL:
							next_s.hrdata[1:0] = s.sel;
						msgbuf_pkg::REG_STAT:
							next_s.hrdata[`MSGBUF_NEV-1:0] = status;
						msgbuf_pkg::REG_MASK:
							next_s.hrdata[`MSGBUF_NEV-1:0] = mask;
						msgbuf_pkg::REG_PTR:
							next_s.hrdata[17:0] = {s.spent, 1'b0, s.ptr1, 1'b0, s.ptr0};
						default: begin
						end
					endcase
				end
			end
		endcase
		// engine events restart the pointer of the buffer they name
		if (ev_set[`MSGBUF_EV_RX_END_OF_TRANSFER_EVENT] || ev_set[`MSGBUF_EV_TXSENT]) begin
			rs0 = rs0 || !ENG_BUF;
			rs1 = rs1 || ENG_BUF;
			next_s.spent[ENG_BUF] = ev_set[`MSGBUF_EV_TXSENT];
		end
		// wrap after the last byte; a restart outranks an advance
		if (rs0) begin
			next_s.ptr0 = 7'h00;
		end else if (adv0) begin
			next_s.ptr0 = (s.ptr0 == LAST) ? 7'h00 : s.ptr0 + 7'h01;
		end
		if (rs1) begin
			next_s.ptr1 = 7'h00;
		end else if (adv1) begin
			next_s.ptr1 = (s.ptr1 == LAST) ? 7'h00 : s.ptr1 + 7'h01;
		end
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			s <= '{bst: msgbuf_pkg::BUS_IDLE, rsel: msgbuf_pkg::REG_NONE,
				sel: `MSGBUF_SEL_RESET, hreadyout: 1'b1, default: '0};
		end else begin
			s <= next_s;
		end
	end

	// irq is registered again so every output except the tied-off HRESP leaves a flop
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= irq_w;
		end
	end

	assign HRDATA    = s.hrdata;
	assign HREADYOUT = s.hreadyout;
	assign HRESP     = 1'b0; // always OKAY
	assign CTRL_SEL  = s.sel;
	assign ENG_RDATA = mi.b_rdata;

	// checks on the port behaviour
	chk_wait_then_ready: assert property (
		@(posedge CLK) disable iff (!rst_n)
		accept |=> !HREADYOUT ##1 HREADYOUT)
		else $error("transfer not answered after one wait state");
	chk_read_advance: assert property (
		@(posedge CLK) disable iff (!rst_n)
		accept && !HWRITE && dec == msgbuf_pkg::REG_BUF0 && !ev_set[0] &&
		!ev_set[1] |=> s.ptr0 == (($past(s.ptr0) == LAST) ? 7'h00 :
		$past(s.ptr0) + 7'h01))
		else $error("buffer 0 pointer did not advance on read");
	chk_write_advance: assert property (
		@(posedge CLK) disable iff (!rst_n)
		s.bst == msgbuf_pkg::BUS_RESP && s.wr &&
		s.rsel == msgbuf_pkg::REG_BUF1 && ev_set == '0
		|=> s.ptr1 == (($past(s.ptr1) == LAST) ? 7'h00 :
		$past(s.ptr1) + 7'h01))
		else $error("buffer 1 pointer did not advance on write");
	chk_ptr_in_range: assert property (
		@(posedge CLK) disable iff (!rst_n)
		s.ptr0 <= LAST && s.ptr1 <= LAST)
		else $error("byte pointer beyond buffer end");
	chk_engine_range: assert property (
		@(posedge CLK) disable iff (!rst_n)
		(ENG_RD || ENG_WR) && ENG_ADDR > LAST
		|-> int'(mi.b_addr) >= 2 * DEPTH)
		else $error("engine index past the end reached a buffer");
	chk_engine_gated: assert property (
		@(posedge CLK) disable iff (!rst_n)
		(ENG_CTRL != CTRL_SEL) |-> !mi.b_en && ev_set == '0)
		else $error("unselected controller reached the buffers");
	chk_select_write: assert property (
		@(posedge CLK) disable iff (!rst_n)
		s.bst == msgbuf_pkg::BUS_RESP && s.wr &&
		s.rsel == msgbuf_pkg::REG_CTRL |=> CTRL_SEL ==
		$past(HWDATA[`MSGBUF_CTRL_SEL_HI:`MSGBUF_CTRL_SEL_LO]))
		else $error("controller select not taken from the write");
	chk_sent_mark: assert property (
		@(posedge CLK) disable iff (!rst_n)
		ev_set[`MSGBUF_EV_TXSENT] && !ENG_BUF |=> s.spent[0])
		else $error("sent message not marked in buffer 0");
	chk_sent_blank: assert property (
		@(posedge CLK) disable iff (!rst_n)
		s.bst == msgbuf_pkg::BUS_RESP && !s.wr && s.spent[0] &&
		s.rsel == msgbuf_pkg::REG_BUF0 |=> HRDATA == 32'h0)
		else $error("sent buffer content still readable");
	chk_eot_restart: assert property (
		@(posedge CLK) disable iff (!rst_n)
		ev_set[`MSGBUF_EV_RX_END_OF_TRANSFER_EVENT] && !ENG_BUF |=> s.ptr0 == 7'h00)
		else $error("pointer not restarted at end of transfer");
	chk_buf1_restart: assert property (
		@(posedge CLK) disable iff (!rst_n)
		ev_set != '0 && ENG_BUF |=> s.ptr1 == 7'h00)
		else $error("buffer 1 pointer not restarted by engine event");
	chk_ctrl_restart: assert property (
		@(posedge CLK) disable iff (!rst_n)
		s.bst == msgbuf_pkg::BUS_RESP && s.wr &&
		s.rsel == msgbuf_pkg::REG_CTRL && HWDATA[`MSGBUF_CTRL_RST0]
		|=> s.ptr0 == 7'h00)
		else $error("buffer 0 pointer not restarted by control write");
	chk_rx_bytes: assert property (
		@(posedge CLK) disable iff (!rst_n)
		accept && !HWRITE && dec == msgbuf_pkg::REG_BUF0 && !s.spent[0]
		|=> ##1 HRDATA == {24'h0, $past(mi.a_rdata)})
		else $error("buffer 0 read returned wrong byte");
	chk_buf1_window: assert property (
		@(posedge CLK) disable iff (!rst_n)
		accept && !HWRITE && dec == msgbuf_pkg::REG_BUF1
		|-> mi.a_addr >= BASE1)
		else $error("buffer 1 access landed in buffer 0");

	// main scenarios the bench is expected to reach
	cov_buf0_read: cover property (@(posedge CLK) disable iff (!rst_n)
		accept && !HWRITE && dec == msgbuf_pkg::REG_BUF0);
	cov_buf1_write: cover property (@(posedge CLK) disable iff (!rst_n)
		accept && HWRITE && dec == msgbuf_pkg::REG_BUF1);
	cov_eot_irq: cover property (@(posedge CLK) disable iff (!rst_n)
		ev_set[`MSGBUF_EV_RX_END_OF_TRANSFER_EVENT] ##[1:4] IRQ);
	cov_sent_hidden: cover property (@(posedge CLK) disable iff (!rst_n)
		s.bst == msgbuf_pkg::BUS_RESP && !s.wr && s.spent[0] &&
		s.rsel == msgbuf_pkg::REG_BUF0);
	cov_buf1_restart: cover property (@(posedge CLK) disable iff (!rst_n)
		ev_set != '0 && ENG_BUF);
endmodule // lapd_msg_port

/* File: tb/lapd_msg_port_tb.sv */
// self-checking bench for the message buffer port, register side over ahb
// assumes msgbuf_defs.svh on the include path and a single ahb slave
`include "msgbuf_defs.svh"
module lapd_msg_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [11:0] buf0_a = `MSGBUF_OFF_BUF0;
	localparam logic [11:0] buf1_a = `MSGBUF_OFF_BUF1;
	localparam logic [11:0] ctrl_a = `MSGBUF_OFF_CTRL;
	localparam logic [11:0] stat_a = `MSGBUF_OFF_STAT;
	localparam logic [11:0] mask_a = `MSGBUF_OFF_MASK;
	localparam logic [11:0] ptr_a  = `MSGBUF_OFF_PTR;
	logic        clk = 1'h0;
	logic        arst_n = 1'h0;
	logic        hsel = 1'h0;
	logic        hwrite = 1'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        irq;
	logic [1:0]  ctrl_sel;
	logic [1:0]  eng_ctrl = 2'h0;
	logic        eng_rd = 1'h0;
	logic        eng_wr = 1'h0;
	logic        eng_buf = 1'h0;
	logic [6:0]  eng_addr = 7'h0;
	logic [7:0]  eng_wdata = 8'h0;
	logic [7:0]  eng_rdata;
	logic        eng_tx = 1'h0;
	logic        eng_rx = 1'h0;
	logic        rdy_p;
	logic [31:0] rdat_p;
	int          num_errors = 0;
	int          total_checks = 0;

	// one slave on the bus, so its ready is fed back as the bus ready
	lapd_msg_port lapd_msg_port_i (
		.CLK(clk), .ARST_N(arst_n), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
		.HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
		.HRESP(hresp), .IRQ(irq), .CTRL_SEL(ctrl_sel), .ENG_CTRL(eng_ctrl),
		.ENG_RD(eng_rd), .ENG_WR(eng_wr), .ENG_BUF(eng_buf),
		.ENG_ADDR(eng_addr), .ENG_WDATA(eng_wdata), .ENG_RDATA(eng_rdata),
		.ENG_TX_SENT(eng_tx), .ENG_RX_EOT(eng_rx)
	);

	// 250 mhz clock
	always #2 clk = ~clk;

	// capture ready and data mid-cycle so the next edge sees them race-free
	always @(negedge clk) begin
		rdy_p = hreadyout;
		rdat_p = hrdata;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// one single word transfer: address phase, then data phase
	task automatic bus(input logic wr, input logic [11:0] a,
		input logic [31:0] wd, output logic [31:0] rdv);
		int n;
		n = 0;
		hsel <= 1'h1;
		haddr <= {20'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do begin
			@(posedge clk);
			n++;
		end while (rdy_p !== 1'b1 && n < 50);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= wd;
		do begin
			@(posedge clk);
			n++;
		end while (rdy_p !== 1'b1 && n < 50);
		rdv = rdat_p;
		chk({31'h0, n < 50}, 32'h1, "bus wait");
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] e,
		input string w);
		logic [31:0] x;
		bus(1'b0, a, 32'h0, x);
		chk(x, e, w);
	endtask

	// one-cycle engine strobe: rx end-of-transfer or tx sent
	task automatic eng_ev(input logic [1:0] c, input logic b, input logic rx);
		eng_ctrl <= c;
		eng_buf <= b;
		if (rx) eng_rx <= 1'h1;
		else eng_tx <= 1'h1;
		@(posedge clk);
		eng_rx <= 1'h0;
		eng_tx <= 1'h0;
		@(posedge clk);
	endtask

	task automatic eng_w(input logic [1:0] c, input logic b,
		input logic [6:0] a, input logic [7:0] d);
		eng_ctrl <= c;
		eng_buf <= b;
		eng_addr <= a;
		eng_wdata <= d;
		eng_wr <= 1'h1;
		@(posedge clk);
		eng_wr <= 1'h0;
		@(posedge clk);
	endtask

	// read data is a flop, looked at once the edge after the strobe settles
	task automatic eng_r(input logic [1:0] c, input logic b,
		input logic [6:0] a, input logic [7:0] e);
		eng_ctrl <= c;
		eng_buf <= b;
		eng_addr <= a;
		eng_rd <= 1'h1;
		@(posedge clk);
		eng_rd <= 1'h0;
		@(posedge clk);
		#1;
		chk({24'h0, eng_rdata}, {24'h0, e}, "engine read");
	endtask

	function automatic logic [31:0] pat(input int i);
		return {24'h0, 8'(i * 7 + 3)};
	endfunction

	task final_report;
		$display("errors %0d checks %0d", num_errors, total_checks);
		if (num_errors == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// watchdog: the sequence needs roughly 750 cycles
	initial begin
		#40000;
		num_errors++;
		$display("[FAIL] %0t watchdog expired", $time);
		final_report;
	end

	// main sequence
	initial begin
		repeat (12) @(posedge clk);
		arst_n <= 1'h1;
		repeat (4) @(posedge clk);
		#1;
		chk({31'h0, hreadyout}, 32'h1, "ready idle");
		chk({31'h0, irq}, 32'h0, "irq at reset");
		rdc(ctrl_a, 32'h0, "ctrl reset");
		wr(ctrl_a, 32'h2);
		chk({30'h0, ctrl_sel}, 32'h2, "select port");
		rdc(ctrl_a, 32'h2, "select read");
		eng_w(2'h2, 1'h0, 7'h0, 8'h3c);
		eng_w(2'h1, 1'h0, 7'h0, 8'h11);
		rdc(buf0_a, 32'h3c, "unselected engine");
		wr(ctrl_a, 32'h102);
		for (int i = 0; i < 96; i++) wr(buf0_a, pat(i));
		rdc(ptr_a, 32'h0, "pointer wraps");
		for (int i = 0; i < 96; i++) rdc(buf0_a, pat(i), "buf0 read");
		eng_r(2'h2, 1'h0, 7'h5f, 8'(pat(95)));
		wr(ctrl_a, 32'h202);
		for (int i = 0; i < 3; i++) wr(buf1_a, 32'hc0 + i);
		rdc(ptr_a, 32'h300, "buf1 pointer");
		eng_w(2'h2, 1'h0, 7'h60, 8'h5a);
		eng_r(2'h2, 1'h1, 7'h0, 8'hc0);
		eng_r(2'h2, 1'h0, 7'h60, 8'h00);
		eng_r(2'h2, 1'h1, 7'h1, 8'hc1);
		wr(ctrl_a, 32'h202);
		for (int i = 0; i < 3; i++) rdc(buf1_a, 32'hc0 + i, "buf1");
		rdc(buf0_a, pat(0), "buf0 kept");
		wr(mask_a, 32'h1);
		rdc(mask_a, 32'h1, "mask");
		eng_ev(2'h2, 1'h0, 1'h1);
		rdc(ptr_a, 32'h300, "eot restart");
		chk({31'h0, irq}, 32'h1, "irq raised");
		rdc(stat_a, 32'h1, "eot status");
		rdc(stat_a, 32'h0, "status cleared");
		repeat (3) @(posedge clk);
		chk({31'h0, irq}, 32'h0, "irq cleared");
		eng_ev(2'h0, 1'h0, 1'h1);
		rdc(stat_a, 32'h0, "foreign event");
		eng_ev(2'h2, 1'h0, 1'h0);
		repeat (3) @(posedge clk);
		chk({31'h0, irq}, 32'h0, "masked event");
		rdc(stat_a, 32'h2, "sent status");
		rdc(ptr_a, 32'h10300, "sent flag");
		rdc(buf0_a, 32'h0, "sent hidden");
		wr(ctrl_a, 32'h102);
		wr(buf0_a, 32'h77);
		wr(ctrl_a, 32'h102);
		rdc(buf0_a, 32'h77, "rewritten");
		rdc(ptr_a, 32'h301, "flag cleared");
		// a received message: engine fills buffer 0, then signals the end
		for (int i = 0; i < 4; i++) begin
			eng_w(2'h2, 1'h0, 7'(i), 8'ha0 + 8'(i));
		end
		eng_ev(2'h2, 1'h0, 1'h1);
		rdc(stat_a, 32'h1, "rx status");
		for (int i = 0; i < 4; i++) begin
			rdc(buf0_a, 32'ha0 + i, "rx message");
		end
		eng_ev(2'h2, 1'h1, 1'h1);
		rdc(ptr_a, 32'h4, "buf1 restart");
		wr(12'h010, 32'hffff);
		rdc(12'h010, 32'h0, "unmapped");
		chk({31'h0, hresp}, 32'h0, "okay");
		final_report;
	end
endmodule // lapd_msg_port_tb
